/* File: design/fee_cfg.svh */
`ifndef FEE_CFG_SVH
`define FEE_CFG_SVH
// Behaviour
// R01: Estimator runs only with control low bits 11
// R02: Host writes control low bits only 11 or 00
// R03: Period counter triggers after selected bit count
// R04: Up pulse adds one, down pulse subtracts one
// R05: Trigger copies tally to result, clears accumulator
// R06: Result readable at register address 22 (0x16)
// R07: Result is eight-bit two's complement value
// R08: Reads return last captured value, not live
// R09: Accumulator wraps, plus 127 becomes minus 128
// R10: Positive result means signal above tuned carrier
// R11: Host measures over 8 or 16 bit periods; the host select also offers 32 and 64
// R12: Host starts trim 16, step 16, direction negative
// R13: Halve step, adjust trim, write, wait, read
// R14: Host uses sign only; above zero is positive
// R15: Positive lowers trim code, negative raises it
// R16: Loop while step above 1; positive then minus one
// R17: Result register eight bits, read only
// R18: Inactive estimator holds counters cleared

// Device register port
`define FEE_ADDR_CONTROL 7'h15
`define FEE_ADDR_RESULT  7'h16
`define FEE_ADDR_TRIM    7'h0a
`define FEE_RST_CONTROL  8'h00
`define FEE_RST_TRIM     5'h10
`define FEE_CTL_EN_LSB   0
`define FEE_CTL_SEL_LSB  2
`define FEE_CTL_ON       2'h3
`define FEE_CTL_OFF      2'h0
// Bits per measurement for each select code
`define FEE_BITS_SEL0    7'h08
`define FEE_BITS_SEL1    7'h10
`define FEE_BITS_SEL2    7'h20
`define FEE_BITS_SEL3    7'h40

// Host AXI4-Lite map
`define FEE_AXI_CTRL     4'h0
`define FEE_AXI_STATUS   4'h4
`define FEE_CTRL_START   0
`define FEE_CTRL_SEL_LSB 2
`define FEE_RST_SEL      2'h0
`define FEE_INIT_TRIM    5'h10
`define FEE_INIT_STEP    5'h10
`define FEE_RESP_OKAY    2'h0
`define FEE_RESP_SLVERR  2'h2
`endif

/* File: design/fee_pkg.sv */
package fee_pkg;
  typedef logic [6:0]        fee_addr_t;
  typedef logic [7:0]        fee_byte_t;
  typedef logic signed [7:0] fee_result_t;
  typedef logic [4:0]        fee_trim_t;
  typedef enum logic [7:0] {
    FEE_H_IDLE   = 8'b0000_0001,
    FEE_H_CFG    = 8'b0000_0010,
    FEE_H_STEP   = 8'b0000_0100,
    FEE_H_WRITE  = 8'b0000_1000,
    FEE_H_WAIT   = 8'b0001_0000,
    FEE_H_READ   = 8'b0010_0000,
    FEE_H_RWAIT  = 8'b0100_0000,
    FEE_H_DONE   = 8'b1000_0000
  } fee_host_state_e;
endpackage

/* File: design/fee_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface fee_link_if
  import fee_pkg::*;
();
  logic      reg_wr_en;
  logic      reg_rd_en;
  fee_addr_t reg_addr;
  fee_byte_t reg_wdata;
  fee_byte_t reg_rdata;
  logic      reg_rvalid;
  modport dev (
    input  reg_wr_en, reg_rd_en, reg_addr, reg_wdata,
    output reg_rdata, reg_rvalid
  );
  modport host (
    output reg_wr_en, reg_rd_en, reg_addr, reg_wdata,
    input  reg_rdata, reg_rvalid
  );
endinterface
`default_nettype wire

/* File: design/fee_dev.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fee_cfg.svh"
module fee_dev (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  // Register port
  fee_link_if.dev           link,
  // Demodulator side
  input  wire logic         up_pulse_strobe,
  input  wire logic         down_pulse_strobe,
  input  wire logic         bit_period_tick,
  // Radio side
  output logic              crystal_trim,
  output fee_pkg::fee_trim_t trim_code,
  output logic              estimator_active,
  output logic              measure_trigger
);
  import fee_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Register state
  fee_byte_t   control_q;
  fee_byte_t   control_d;
  fee_trim_t   trim_q;
  fee_trim_t   trim_d;
  fee_byte_t   rdata_q;
  fee_byte_t   rdata_d;
  logic        rvalid_q;
  logic        rvalid_d;
  fee_result_t result_q;
  fee_result_t result_d;

  ////////////////////////////////////////////////////////////////////
  // Measurement state
  logic [6:0]  period_cnt_q;
  logic [6:0]  period_cnt_d;
  fee_result_t acc_q;
  fee_result_t acc_d;
  logic        active;
  logic        trigger;
  logic [6:0]  bits_per_meas;
  logic [1:0]  enable_bits;
  logic [1:0]  select_bits;
  fee_result_t acc_next;

  assign enable_bits = control_q[`FEE_CTL_EN_LSB +: 2];
  assign select_bits = control_q[`FEE_CTL_SEL_LSB +: 2];

  // Mixed enable codes are not allowed; treat them as off
  assign active = (enable_bits == `FEE_CTL_ON); // [R01]

  always_comb begin
    case (select_bits)
      2'h0: bits_per_meas = `FEE_BITS_SEL0;
      2'h1: bits_per_meas = `FEE_BITS_SEL1;
      2'h2: bits_per_meas = `FEE_BITS_SEL2;
      2'h3: bits_per_meas = `FEE_BITS_SEL3;
      default: bits_per_meas = `FEE_BITS_SEL0;
    endcase
  end

  // Trigger on the tick that completes the selected count
  assign trigger = active && bit_period_tick &&
                   (period_cnt_q == bits_per_meas - 7'h01); // [R03]

  ////////////////////////////////////////////////////////////////////
  // Accumulator and period counter
  always_comb begin
    acc_next = acc_q;
    // Coincident up and down cancel; 8-bit math wraps, never clamps
    if (up_pulse_strobe && !down_pulse_strobe) begin
      acc_next = acc_q + 8'sh01; // [R04] [R09]
    end else if (down_pulse_strobe && !up_pulse_strobe) begin
      acc_next = acc_q - 8'sh01; // [R04] [R09]
    end
    period_cnt_d = period_cnt_q;
    acc_d        = acc_q;
    result_d     = result_q;
    if (!active) begin
      period_cnt_d = 7'h00; // [R18]
      acc_d        = 8'sh00; // [R18]
    end else if (trigger) begin
      // Pulse seen in the trigger cycle is counted, not dropped
      result_d     = acc_next; // [R05] [R07] [R10]
      acc_d        = 8'sh00; // [R05]
      period_cnt_d = 7'h00; // [R03]
    end else begin
      acc_d = acc_next; // [R04]
      if (bit_period_tick) begin
        period_cnt_d = period_cnt_q + 7'h01; // [R03]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      period_cnt_q <= 7'h00;
      acc_q        <= 8'sh00;
      result_q     <= 8'sh00;
    end else begin
      period_cnt_q <= period_cnt_d;
      acc_q        <= acc_d;
      result_q     <= result_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register port
  always_comb begin
    control_d = control_q;
    trim_d    = trim_q;
    rdata_d   = rdata_q;
    rvalid_d  = 1'b0;
    if (link.reg_wr_en) begin
      case (link.reg_addr)
        `FEE_ADDR_CONTROL: begin
          control_d = {4'h0, link.reg_wdata[3:0]};
        end
        `FEE_ADDR_TRIM: begin
          trim_d = link.reg_wdata[4:0];
        end
        // Result address falls here: writes are dropped
        default: begin
          control_d = control_q; // [R17]
        end
      endcase
    end
    if (link.reg_rd_en) begin
      rvalid_d = 1'b1;
      case (link.reg_addr)
        `FEE_ADDR_CONTROL: begin
          rdata_d = control_q;
        end
        `FEE_ADDR_TRIM: begin
          rdata_d = {3'h0, trim_q};
        end
        // Captured value only, never the live tally
        `FEE_ADDR_RESULT: begin
          rdata_d = result_q; // [R06] [R08] [R17]
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      control_q <= `FEE_RST_CONTROL;
      trim_q    <= `FEE_RST_TRIM;
      rdata_q   <= 8'h00;
      rvalid_q  <= 1'b0;
    end else begin
      control_q <= control_d;
      trim_q    <= trim_d;
      rdata_q   <= rdata_d;
      rvalid_q  <= rvalid_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign link.reg_rdata  = rdata_q;
  assign link.reg_rvalid = rvalid_q;
  assign trim_code       = trim_q;
  assign crystal_trim    = 1'b0;
  assign estimator_active = active;
  assign measure_trigger  = trigger;

endmodule
`default_nettype wire

/* File: design/fee_host.sv */
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "fee_cfg.svh"
module fee_host (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Device port
  fee_link_if.host         link,
  // Recovered bit clock
  input  wire logic        bit_period_tick,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import fee_pkg::*;

  fee_host_state_e st_q, st_d;
  fee_trim_t   present_q, present_d;
  logic [4:0]  step_q, step_d;
  logic        pos_q, pos_d;
  logic [6:0]  wait_q, wait_d;
  fee_result_t last_q, last_d;
  logic [1:0]  sel_q, sel_d;
  logic        done_q, done_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic        wr_go, start;
  logic [6:0]  meas_bits;

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave, both address and data taken together
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = !rvalid_q;
  assign start = wr_go && (s_axi_awaddr == `FEE_AXI_CTRL) && s_axi_wstrb[0] &&
                 s_axi_wdata[`FEE_CTRL_START];

  always_comb begin
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q && !s_axi_rready;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    sel_d    = sel_q;
    if (wr_go) begin
      bvalid_d = 1'b1;
      bresp_d  = `FEE_RESP_OKAY;
      if (s_axi_awaddr == `FEE_AXI_CTRL) begin
        // Select is frozen while a search runs
        if (s_axi_wstrb[0] && st_q == FEE_H_IDLE) begin
          sel_d = s_axi_wdata[`FEE_CTRL_SEL_LSB +: 2];
        end
      end else if (s_axi_awaddr != `FEE_AXI_STATUS) begin
        bresp_d = `FEE_RESP_SLVERR;
      end
    end
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d  = `FEE_RESP_OKAY;
      case (s_axi_araddr)
        `FEE_AXI_CTRL:   rdata_d = {28'h000_0000, sel_q, 2'h0};
        `FEE_AXI_STATUS: rdata_d = {8'h00, last_q, 3'h0, present_q,
                                    6'h00, done_q, (st_q != FEE_H_IDLE)};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = `FEE_RESP_SLVERR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Trim search
  always_comb begin
    case (sel_q)
      2'h0: meas_bits = `FEE_BITS_SEL0;
      2'h1: meas_bits = `FEE_BITS_SEL1;
      2'h2: meas_bits = `FEE_BITS_SEL2;
      default: meas_bits = `FEE_BITS_SEL3;
    endcase
  end

  always_comb begin
    st_d = st_q;
    present_d = present_q;
    step_d = step_q;
    pos_d = pos_q;
    wait_d = wait_q;
    last_d = last_q;
    done_d = done_q;
    link.reg_wr_en = 1'b0;
    link.reg_rd_en = 1'b0;
    link.reg_addr  = `FEE_ADDR_RESULT;
    link.reg_wdata = 8'h00;
    case (st_q)
      FEE_H_IDLE: begin
        if (start) begin
          present_d = `FEE_INIT_TRIM; // [R12]
          step_d    = `FEE_INIT_STEP; // [R12]
          pos_d     = 1'b0; // [R12]
          done_d    = 1'b0;
          st_d      = FEE_H_CFG;
        end
      end
      FEE_H_CFG: begin
        // Only the all-ones enable code is ever written
        link.reg_wr_en = 1'b1;
        link.reg_addr  = `FEE_ADDR_CONTROL;
        link.reg_wdata = {4'h0, sel_q, `FEE_CTL_ON}; // [R02] [R11]
        st_d = FEE_H_STEP;
      end
      FEE_H_STEP: begin
        step_d = {1'b0, step_q[4:1]}; // [R13]
        if (pos_q) begin
          present_d = present_q - step_d; // [R15]
        end else begin
          present_d = present_q + step_d; // [R15]
        end
        st_d = FEE_H_WRITE;
      end
      FEE_H_WRITE: begin
        link.reg_wr_en = 1'b1;
        link.reg_addr  = `FEE_ADDR_TRIM;
        link.reg_wdata = {3'h0, present_q}; // [R13]
        wait_d = 7'h00;
        st_d   = FEE_H_WAIT;
      end
      FEE_H_WAIT: begin
        // One extra tick so a whole fresh period is captured
        if (bit_period_tick) begin
          wait_d = wait_q + 7'h01;
          if (wait_q == meas_bits) begin
            st_d = FEE_H_READ; // [R13]
          end
        end
      end
      FEE_H_READ: begin
        link.reg_rd_en = 1'b1;
        st_d = FEE_H_RWAIT;
      end
      FEE_H_RWAIT: begin
        if (link.reg_rvalid) begin
          last_d = link.reg_rdata;
          pos_d  = ($signed(link.reg_rdata) > 8'sh00); // [R14]
          if (step_q > 5'h01) begin
            st_d = FEE_H_STEP; // [R16]
          end else begin
            if ($signed(link.reg_rdata) > 8'sh00) begin
              present_d = present_q - 5'h01; // [R16]
            end
            st_d = FEE_H_DONE;
          end
        end
      end
      FEE_H_DONE: begin
        link.reg_wr_en = 1'b1;
        link.reg_addr  = `FEE_ADDR_TRIM;
        link.reg_wdata = {3'h0, present_q};
        done_d = 1'b1;
        st_d   = FEE_H_IDLE;
      end
      default: st_d = FEE_H_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= FEE_H_IDLE;
      present_q <= `FEE_INIT_TRIM;
      step_q <= `FEE_INIT_STEP;
      pos_q <= 1'b0;
      wait_q <= 7'h00;
      last_q <= 8'sh00;
      sel_q <= `FEE_RST_SEL;
      done_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `FEE_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= `FEE_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      present_q <= present_d;
      step_q <= step_d;
      pos_q <= pos_d;
      wait_q <= wait_d;
      last_q <= last_d;
      sel_q <= sel_d;
      done_q <= done_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;

endmodule
`default_nettype wire

/* File: tb/fee_link_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fee_cfg.svh"
module fee_link_checker (
  // Clock and reset
  input wire logic               core_clk,
  input wire logic               sys_rst,
  // Link signals
  input wire logic               reg_wr_en,
  input wire logic               reg_rd_en,
  input wire fee_pkg::fee_addr_t reg_addr,
  input wire fee_pkg::fee_byte_t reg_wdata,
  input wire fee_pkg::fee_byte_t reg_rdata,
  input wire logic               reg_rvalid
);
  import fee_pkg::*;
  logic      first_q;
  logic      seen_q;
  logic      pos_q;
  fee_trim_t last_q;
  wire       trim_wr = reg_wr_en && (reg_addr == `FEE_ADDR_TRIM);
  wire       ctl_wr  = reg_wr_en && (reg_addr == `FEE_ADDR_CONTROL);
  //////////////////////////////////////////////////
  // Search history: first trim after enable, last trim, last sign
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      first_q <= 1'b0;
      seen_q  <= 1'b0;
    end else if (ctl_wr) begin
      first_q <= 1'b1;
      seen_q  <= 1'b0;
    end else if (trim_wr) begin
      first_q <= 1'b0;
      last_q  <= reg_wdata[4:0];
    end else if (reg_rvalid) begin
      seen_q  <= 1'b1;
      pos_q   <= $signed(reg_rdata) > 0;
    end
  end
  //////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  rd_answer_a: assert property (reg_rd_en |=> reg_rvalid)
    else $error("read not answered next cycle");
  rv_cause_a: assert property (reg_rvalid |-> $past(reg_rd_en))
    else $error("answer without read");
  rdata_hold_a: assert property (!reg_rvalid && !$past(sys_rst) |-> $stable(reg_rdata))
    else $error("read data moved without read");
  ctl_value_a: assert property (ctl_wr |-> reg_wdata[1:0] inside {2'h3, 2'h0})
    else $error("mixed enable code written");
  result_ro_a: assert property (reg_wr_en |-> reg_addr != `FEE_ADDR_RESULT)
    else $error("write to result register");
  rd_target_a: assert property (reg_rd_en |-> reg_addr == `FEE_ADDR_RESULT)
    else $error("read of other than result");
  first_trim_a: assert property (trim_wr && first_q |-> reg_wdata[4:0] == 5'h18)
    else $error("first trim not 24");
  trim_dir_a: assert property (trim_wr && seen_q |->
    (pos_q ? reg_wdata[4:0] < last_q : reg_wdata[4:0] >= last_q))
    else $error("trim moved the wrong way");
  trim_wait_a: assert property (trim_wr |=> !reg_rd_en [*8])
    else $error("result read too soon after trim");
endmodule
`default_nettype wire

/* File: tb/test_frequency_error_estimator.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fee_cfg.svh"
module test_frequency_error_estimator;
  import fee_pkg::*;
  typedef struct packed {logic [1:0] resp; logic [31:0] data; logic [31:0] mask;} fee_exp_s;
  logic        core_clk, sys_rst, up_s, down_s, tick, dense, pos, trig, active_o, hit;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [3:0]  awaddr, araddr, wstrb, ctl;
  logic [31:0] wdata, rdata, got, rnd;
  logic [1:0]  bresp, rresp, tcnt;
  logic [6:0]  cnt;
  fee_trim_t   trim_code, target, pres, step, nxt;
  fee_byte_t   acc, res, rd_exp;
  fee_exp_s    e;
  fee_exp_s    exp_q[$];
  int          miscompares, tests_run;
  fee_link_if  link();
  //////////////////////////////////////////////////
  fee_dev fee_dev_i (.core_clk(core_clk), .sys_rst(sys_rst), .link(link),
    .up_pulse_strobe(up_s), .down_pulse_strobe(down_s), .bit_period_tick(tick),
    .crystal_trim(), .trim_code(trim_code), .estimator_active(active_o),
    .measure_trigger(trig));
  fee_host fee_host_i (.core_clk(core_clk), .sys_rst(sys_rst), .link(link),
    .bit_period_tick(tick), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  fee_link_checker fee_link_checker_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_wr_en(link.reg_wr_en), .reg_rd_en(link.reg_rd_en), .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata), .reg_rvalid(link.reg_rvalid));
  //////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    exp_q.push_back('{er, 32'h0, 32'h0});
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    // Requests land after this step, so test only after an edge
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) bready <= 1'b0;
    end while (awvalid || wvalid || bready);
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m,
                        input logic [1:0] er);
    exp_q.push_back('{er, d, m});
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        rready <= 1'b0;
        got = rdata;
      end
    end while (arvalid || rready);
  endtask
  //////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Demodulator: pulses follow trim against the transmitter's slot
  always @(posedge core_clk) begin
    rnd = $urandom;
    tcnt <= tcnt + 2'h1;
    tick <= (tcnt == 2'h3);
    up_s <= (trim_code > target && (dense || rnd[0])) || rnd[3:1] == 3'h0;
    down_s <= (trim_code < target && (dense || rnd[0])) || rnd[3:1] == 3'h0;
  end
  // Reference estimator and search, fed from the link traffic
  always @(posedge core_clk) begin
    if (sys_rst) begin
      ctl <= 4'h0; acc <= 8'h00; cnt <= 7'h00; res <= 8'h00;
      pres <= `FEE_INIT_TRIM; step <= `FEE_INIT_STEP; pos <= 1'b0;
    end else begin
      hit = (ctl[1:0] == 2'h3) && tick && (cnt + 7'h01 == (7'h08 << ctl[3:2]));
      if (hit || trig !== 1'b0) check("trigger", {31'h0, hit}, {31'h0, trig});
      if (ctl[0] || active_o !== 1'b0)
        check("active", {31'h0, ctl[1:0] == 2'h3}, {31'h0, active_o});
      if (ctl[1:0] != 2'h3) begin
        acc <= 8'h00;
        cnt <= 7'h00;
      end else if (hit) begin
        res <= acc + 8'(up_s) - 8'(down_s);
        acc <= 8'h00;
        cnt <= 7'h00;
      end else begin
        acc <= acc + 8'(up_s) - 8'(down_s);
        cnt <= cnt + 7'(tick);
      end
      if (link.reg_wr_en && link.reg_addr == `FEE_ADDR_CONTROL) ctl <= link.reg_wdata[3:0];
      if (link.reg_rd_en) rd_exp <= res;
      if (link.reg_rvalid) begin
        check("result read", {24'h0, rd_exp}, {24'h0, link.reg_rdata});
        pos <= $signed(rd_exp) > 0;
      end
      if (link.reg_wr_en && link.reg_addr == `FEE_ADDR_TRIM) begin
        if (step > 5'h01) nxt = pos ? pres - (step >> 1) : pres + (step >> 1);
        else nxt = pos ? pres - 5'h01 : pres;
        if (step > 5'h01) step <= step >> 1;
        pres <= nxt;
        check("trim write", {27'h0, nxt}, {24'h0, link.reg_wdata});
      end
    end
  end
  // Bus answers against the oldest note
  always @(posedge core_clk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      e = exp_q.pop_front();
      check("response", {30'h0, e.resp}, {30'h0, bvalid ? bresp : rresp});
      if (rvalid) check("read data", e.data & e.mask, rdata & e.mask);
    end
  end
  initial begin
    #40000;
    miscompares++;
    close_out();
  end
  //////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1; tcnt = 2'h0; tick = 1'b0; up_s = 1'b0; down_s = 1'b0; dense = 1'b0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; wstrb = 4'hf; target = 5'h00;
    miscompares = 0; tests_run = 0;
    void'($urandom(86));
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    @(posedge core_clk);
    check("trim after reset", 32'h10, {27'h0, trim_code});
    axi_rd(`FEE_AXI_STATUS, 32'h0000_1000, 32'hffff_ffff, `FEE_RESP_OKAY);
    axi_rd(4'h8, 32'h0000_0000, 32'hffff_ffff, `FEE_RESP_SLVERR);
    axi_wr(4'hc, 32'h0000_0001, `FEE_RESP_SLVERR);
    axi_wr(`FEE_AXI_STATUS, 32'hffff_ffff, `FEE_RESP_OKAY);
    axi_rd(`FEE_AXI_STATUS, 32'h0000_1000, 32'hffff_ffff, `FEE_RESP_OKAY);
    // Fresh reset per search keeps the period phase known
    for (int sel = 0; sel < 4; sel++) begin
      sys_rst <= 1'b1;
      target <= 5'($urandom_range(31));
      dense <= (sel == 3);
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      axi_wr(`FEE_AXI_CTRL, 32'(sel * 4 + 1), `FEE_RESP_OKAY);
      got = 32'h0;
      for (int i = 0; i < 2000 && got[1] !== 1'b1; i++) begin
        axi_rd(`FEE_AXI_STATUS, 32'h0, 32'h0, `FEE_RESP_OKAY);
      end
      axi_rd(`FEE_AXI_STATUS, {8'h0, rd_exp, 3'h0, pres, 8'h02}, 32'hffff_ffff,
             `FEE_RESP_OKAY);
      check("trim port", {27'h0, pres}, {27'h0, trim_code});
    end
    close_out();
  end
endmodule
`default_nettype wire
